// file: amc_defs.vh
// Register map, field positions and constants of the mode control bank
`ifndef AMC_DEFS_VH
`define AMC_DEFS_VH
// ============================================================
// Register addresses (7-bit)
`define AMC_ADDR_SOFT_RESET 7'h00
`define AMC_ADDR_CONVERTER 7'h01
`define AMC_ADDR_UNUSED 7'h02
`define AMC_ADDR_CLOCK 7'h03
`define AMC_ADDR_OUTPUT_MODE 7'h04
`define AMC_ADDR_DATA_FORMAT 7'h05
// ============================================================
// Reset values and writable masks
`define AMC_RESET_VALUE 8'h00
`define AMC_MASK_CONVERTER 8'h0E
`define AMC_MASK_CLOCK 8'h3F
`define AMC_MASK_OUTPUT_MODE 8'h7D
`define AMC_MASK_DATA_FORMAT 8'h3F
// ============================================================
// Field positions
`define AMC_SOFT_RESET_BIT 7
`define AMC_GAIN_BIT 3
`define AMC_DITHER_OFF_BIT 2
`define AMC_POWER_DOWN_BIT 1
`define AMC_ENC_TERM_BIT 5
`define AMC_KEEPALIVE_BIT 4
`define AMC_OUTCLK_INV_BIT 3
`define AMC_PHASE_HI 2
`define AMC_PHASE_LO 1
`define AMC_DCS_BIT 0
`define AMC_CURRENT_HI 6
`define AMC_CURRENT_LO 4
`define AMC_TERM_BIT 3
`define AMC_HIZ_BIT 2
`define AMC_CMOS_BIT 0
`define AMC_TEST_HI 5
`define AMC_TEST_LO 3
`define AMC_ABP_BIT 2
`define AMC_SCRAMBLER_EN_BIT 1
`define AMC_TWOS_BIT 0
// ============================================================
// Test pattern codes
`define AMC_TP_OFF 3'h0
`define AMC_TP_ZEROS 3'h1
`define AMC_TP_ONES 3'h3
`define AMC_TP_CHECKER 3'h5
`define AMC_TP_ALTERNATE 3'h7
`define AMC_CHECKER_A 17'h15555
`define AMC_CHECKER_B 17'h0AAAA
`define AMC_ODD_MASK 16'hAAAA
// ============================================================
// Frame layout
`define AMC_FRAME_BITS 5'h10
`endif

// file: amc_mode_regs.v
// Mode control register bank with serial port and output formatter
// Function
// R01 - Reset bit clears all registers, self-clears
// R02 - Reset register write-only, reads zero
// R03 - Address 02h and unused bits read zero
// R04 - Bit 3 of 01h selects gain
// R05 - Bit 2 of 01h turns dither off
// R06 - Bit 1 of 01h powers converter down
// R07 - Bit 5 of 03h connects encode termination
// R08 - Bit 4 of 03h disables keep-alive oscillator
// R09 - Bit 3 of 03h inverts forwarded clock
// R10 - Bits 2:1 of 03h set clock delay
// R11 - Host enables stabilizer with nonzero delay
// R12 - Bit 0 of 03h enables duty stabilizer
// R13 - Bits 6:4 of 04h select driver current
// R14 - Bit 3 of 04h doubles current, terminates
// R15 - Bit 2 of 04h puts outputs high-impedance
// R16 - Bit 0 of 04h selects CMOS output
// R17 - Bits 5:3 of 05h select test pattern
// R18 - Checkerboard and alternating swap each sample
// R19 - Host uses only defined pattern codes
// R20 - Bit 2 of 05h enables alternate polarity
// R21 - Bit 1 of 05h enables randomizer
// R22 - Bit 0 of 05h selects two's complement
// R23 - Alternate polarity inverts odd data bits
// R24 - 16-bit frame: read flag, address, data
// R25 - Test pattern overrides all other formatting
`timescale 1ns/100ps
`include "amc_defs.vh"

module amc_mode_regs (
    // Clock, reset, enable
    input wire clk_in,
    input wire rst_n_in,
    input wire clk_en_in,
    // Serial port pins
    input wire spi_cs_n_in,
    input wire spi_sck_in,
    input wire spi_sdi_in,
    output reg spi_sdo_out,
    output reg spi_sdo_oe_out,
    // Sample stream
    input wire sample_valid_in,
    input wire [15:0] sample_data_in,
    input wire sample_overflow_in,
    input wire [15:0] scramble_data_in,
    output reg [15:0] out_data_out,
    output reg overflow_bit_out,
    // Analog and clock controls
    output reg gain_select_out,
    output reg dither_off_n_out,
    output reg power_down_out,
    output reg encode_term_en_out,
    output reg keepalive_osc_off_out,
    output reg outclk_invert_out,
    output reg [1:0] outclk_phase_delay_out,
    output reg duty_stabilizer_en_out,
    // Output driver controls
    output reg [2:0] driver_current_sel_out,
    output reg output_term_en_out,
    output reg output_hiz_out,
    output reg cmos_mode_out,
    // Formatting controls
    output reg [2:0] test_pattern_sel_out,
    output reg alt_polarity_en_out,
    output reg scrambler_en_out,
    output reg signed_format_sel_out
);

    // ============================================================
    // Register readback decode
    function [7:0] amc_read;
        input [6:0] addr;
        input [7:0] conv;
        input [7:0] clkr;
        input [7:0] outm;
        input [7:0] fmt;
        begin
            case (addr)
                `AMC_ADDR_CONVERTER: amc_read = conv;
                `AMC_ADDR_CLOCK: amc_read = clkr;
                `AMC_ADDR_OUTPUT_MODE: amc_read = outm;
                `AMC_ADDR_DATA_FORMAT: amc_read = fmt;
                default: amc_read = 8'h00; // 00h, 02h, unmapped [R02] [R03]
            endcase
        end
    endfunction

    // ============================================================
    // Pin synchronisers
    reg [2:0] sync1_q;
    reg [2:0] sync2_q;
    reg sck_prev_q;
    wire cs_n_s = sync2_q[2];
    wire sck_s = sync2_q[1];
    wire sdi_s = sync2_q[0];
    wire sck_rise = sck_s & ~sck_prev_q;
    wire sck_fall = ~sck_s & sck_prev_q;

    // Two stages before any logic, edge detect only on stage two
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            sync1_q <= 3'h4; // CS high, SCK low: no false edge after reset
            sync2_q <= 3'h4;
            sck_prev_q <= 1'b0;
        end else if (clk_en_in) begin
            sync1_q <= {spi_cs_n_in, spi_sck_in, spi_sdi_in};
            sync2_q <= sync1_q;
            sck_prev_q <= sync2_q[1];
        end
    end

    // ============================================================
    // Frame shifter
    reg [4:0] bit_cnt_q;
    reg [14:0] shift_q;
    reg read_q;
    reg [7:0] rd_shift_q;
    reg [7:0] conv_q;
    reg [7:0] clk_q;
    reg [7:0] outm_q;
    reg [7:0] fmt_q;

    wire in_frame = ~cs_n_s;
    wire last_bit = sck_rise & in_frame & (bit_cnt_q == `AMC_FRAME_BITS - 5'h01);
    wire [15:0] frame = {shift_q, sdi_s};
    wire wr_strobe = last_bit & ~frame[15]; // Reads never update [R24]
    wire [6:0] wr_addr = frame[14:8];
    wire [7:0] wr_data = frame[7:0];
    wire soft_reset = wr_strobe & (wr_addr == `AMC_ADDR_SOFT_RESET) & wr_data[`AMC_SOFT_RESET_BIT];

    // Count 16 rising edges; later edges ignored until CS rises [R24]
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            bit_cnt_q <= 5'h00;
            shift_q <= 15'h0000;
            read_q <= 1'b0;
            rd_shift_q <= 8'h00;
        end else if (clk_en_in) begin
            if (!in_frame) begin
                bit_cnt_q <= 5'h00;
                read_q <= 1'b0;
            end else if (sck_rise && bit_cnt_q < `AMC_FRAME_BITS) begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
                shift_q <= {shift_q[13:0], sdi_s};
                // After address byte, load readback data
                if (bit_cnt_q == 5'h07) begin
                    read_q <= shift_q[6];
                    rd_shift_q <= amc_read({shift_q[5:0], sdi_s}, conv_q, clk_q, outm_q, fmt_q);
                end else if (bit_cnt_q > 5'h07) begin
                    rd_shift_q <= {rd_shift_q[6:0], 1'b0};
                end
            end
        end
    end

    // Open-drain readback: drive low only for zero bits; first bit once the address byte is in, the rest on SCK fall
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            spi_sdo_out <= 1'b0;
            spi_sdo_oe_out <= 1'b0;
        end else if (clk_en_in) begin
            if (!in_frame || !read_q) begin
                spi_sdo_oe_out <= 1'b0;
            end else if (sck_fall || bit_cnt_q == 5'h08) begin
                spi_sdo_oe_out <= ~rd_shift_q[7] & (bit_cnt_q < `AMC_FRAME_BITS);
            end
        end
    end

    // ============================================================
    // Control registers; soft reset clears every one [R01]
    // The reset bit is never stored, so it reads back zero [R01] [R02]
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            conv_q <= `AMC_RESET_VALUE;
            clk_q <= `AMC_RESET_VALUE;
            outm_q <= `AMC_RESET_VALUE;
            fmt_q <= `AMC_RESET_VALUE;
        end else if (clk_en_in) begin
            if (soft_reset) begin
                conv_q <= `AMC_RESET_VALUE; // [R01]
                clk_q <= `AMC_RESET_VALUE;
                outm_q <= `AMC_RESET_VALUE;
                fmt_q <= `AMC_RESET_VALUE;
            end else if (wr_strobe) begin
                // Masks keep unused bits at zero [R03]
                case (wr_addr)
                    `AMC_ADDR_CONVERTER: conv_q <= wr_data & `AMC_MASK_CONVERTER;
                    `AMC_ADDR_CLOCK: clk_q <= wr_data & `AMC_MASK_CLOCK;
                    `AMC_ADDR_OUTPUT_MODE: outm_q <= wr_data & `AMC_MASK_OUTPUT_MODE;
                    `AMC_ADDR_DATA_FORMAT: fmt_q <= wr_data & `AMC_MASK_DATA_FORMAT;
                    default: conv_q <= conv_q;
                endcase
            end
        end
    end

    // ============================================================
    // Control outputs, one flop behind the registers
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            gain_select_out <= 1'b0;
            dither_off_n_out <= 1'b0;
            power_down_out <= 1'b0;
            encode_term_en_out <= 1'b0;
            keepalive_osc_off_out <= 1'b0;
            outclk_invert_out <= 1'b0;
            outclk_phase_delay_out <= 2'h0;
            duty_stabilizer_en_out <= 1'b0;
            driver_current_sel_out <= 3'h0;
            output_term_en_out <= 1'b0;
            output_hiz_out <= 1'b0;
            cmos_mode_out <= 1'b0;
            test_pattern_sel_out <= 3'h0;
            alt_polarity_en_out <= 1'b0;
            scrambler_en_out <= 1'b0;
            signed_format_sel_out <= 1'b0;
        end else if (clk_en_in) begin
            gain_select_out <= conv_q[`AMC_GAIN_BIT]; // [R04]
            dither_off_n_out <= conv_q[`AMC_DITHER_OFF_BIT]; // [R05]
            power_down_out <= conv_q[`AMC_POWER_DOWN_BIT]; // [R06]
            encode_term_en_out <= clk_q[`AMC_ENC_TERM_BIT]; // [R07]
            keepalive_osc_off_out <= clk_q[`AMC_KEEPALIVE_BIT]; // [R08]
            outclk_invert_out <= clk_q[`AMC_OUTCLK_INV_BIT]; // [R09]
            // Delay code passed as is; stabilizer is the host's duty
            outclk_phase_delay_out <= clk_q[`AMC_PHASE_HI:`AMC_PHASE_LO]; // [R10]
            duty_stabilizer_en_out <= clk_q[`AMC_DCS_BIT]; // [R12]
            driver_current_sel_out <= outm_q[`AMC_CURRENT_HI:`AMC_CURRENT_LO]; // [R13]
            output_term_en_out <= outm_q[`AMC_TERM_BIT]; // [R14]
            output_hiz_out <= outm_q[`AMC_HIZ_BIT]; // [R15]
            cmos_mode_out <= outm_q[`AMC_CMOS_BIT]; // [R16]
            test_pattern_sel_out <= fmt_q[`AMC_TEST_HI:`AMC_TEST_LO]; // [R17]
            alt_polarity_en_out <= fmt_q[`AMC_ABP_BIT]; // [R20]
            scrambler_en_out <= fmt_q[`AMC_SCRAMBLER_EN_BIT]; // [R21]
            signed_format_sel_out <= fmt_q[`AMC_TWOS_BIT]; // [R22]
        end
    end

    // ============================================================
    // Sample formatter
    reg phase_q;
    reg [16:0] fmt_word;
    reg [15:0] norm;
    wire [2:0] tp = fmt_q[`AMC_TEST_HI:`AMC_TEST_LO];

    // Pattern first, else two's comp, randomizer, polarity [R25]
    always @* begin
        norm = sample_data_in;
        if (fmt_q[`AMC_TWOS_BIT]) begin
            norm = {~norm[15], norm[14:0]}; // [R22]
        end
        if (fmt_q[`AMC_SCRAMBLER_EN_BIT]) begin
            norm = norm ^ scramble_data_in; // [R21]
        end
        if (fmt_q[`AMC_ABP_BIT]) begin
            norm = norm ^ `AMC_ODD_MASK; // Odd bits only, overflow untouched [R23]
        end
        case (tp)
            `AMC_TP_ZEROS: fmt_word = 17'h00000; // [R17]
            `AMC_TP_ONES: fmt_word = 17'h1FFFF;
            `AMC_TP_CHECKER: fmt_word = phase_q ? `AMC_CHECKER_B : `AMC_CHECKER_A; // [R18]
            `AMC_TP_ALTERNATE: fmt_word = phase_q ? 17'h1FFFF : 17'h00000; // [R18]
            // Undefined codes fall back to normal data
            default: fmt_word = {sample_overflow_in, norm};
        endcase
    end

    // Pattern phase flips on every sample
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            phase_q <= 1'b0;
            out_data_out <= 16'h0000;
            overflow_bit_out <= 1'b0;
        end else if (clk_en_in && sample_valid_in) begin
            phase_q <= ~phase_q;
            out_data_out <= fmt_word[15:0];
            overflow_bit_out <= fmt_word[16];
        end
    end

endmodule

// file: amc_spi_host.sv
// Serial host model that configures the mode control bank
`timescale 1ns/100ps
// ====
// Host
module amc_spi_host (
    // Clock
    input wire clk_in,
    // Serial pins
    input wire sdo_line_in,
    output reg cs_n_out,
    output reg sck_out,
    output reg sdi_out
);
    // Half period kept well above the synchroniser latency
    localparam int HALF = 8;
    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        sdi_out = 1'b0;
    end
    // One frame, MSB first; stop above 0 aborts the frame early
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d, input int stop,
        output logic [7:0] q);
        logic [15:0] w;
        w = {rd, a, d};
        q = 8'h00;
        @(negedge clk_in) cs_n_out = 1'b0;
        for (int i = 15; i >= stop; i--) begin
            sdi_out = w[i];
            repeat (HALF) @(negedge clk_in);
            if (i < 8) q[i] = sdo_line_in;
            sck_out = 1'b1;
            repeat (HALF) @(negedge clk_in);
            sck_out = 1'b0;
        end
        repeat (HALF) @(negedge clk_in);
        cs_n_out = 1'b1;
        sdi_out = ~sdi_out; // No stale data once deselected
        repeat (HALF) @(negedge clk_in);
    endtask
endmodule

// file: amc_mode_regs_monitor.sv
// Port assertions for the mode control bank
`timescale 1ns/100ps
// ====
// Checker
module amc_mode_regs_monitor (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    input wire clk_en_in,
    // Watched ports
    input wire spi_cs_n_in,
    input wire spi_sdo_oe_out,
    input wire sample_valid_in,
    input wire [15:0] sample_data_in,
    input wire [15:0] scramble_data_in,
    input wire [15:0] out_data_out,
    input wire overflow_bit_out,
    input wire gain_select_out,
    input wire [2:0] test_pattern_sel_out,
    input wire alt_polarity_en_out,
    input wire scrambler_en_out,
    input wire signed_format_sel_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Mode held over two cycles so register and output agree
    wire [5:0] fmt = {test_pattern_sel_out, alt_polarity_en_out, scrambler_en_out, signed_format_sel_out};
    wire go = sample_valid_in && clk_en_in;
    wire [16:0] po = {overflow_bit_out, out_data_out};
    AST_RST: assert property ($rose(rst_n_in) |-> fmt == 6'h00 && !gain_select_out && !spi_sdo_oe_out)
        else $error("controls not cleared by reset");
    AST_PLAIN: assert property (go && fmt == 6'h00 ##1 fmt == 6'h00
        |-> out_data_out == $past(sample_data_in))
        else $error("offset binary data altered");
    AST_SIGNED: assert property (go && fmt == 6'h01 ##1 fmt == 6'h01
        |-> out_data_out == ($past(sample_data_in) ^ 16'h8000))
        else $error("signed format wrong");
    AST_SCRAMBLE: assert property (go && fmt == 6'h02 ##1 fmt == 6'h02
        |-> out_data_out == ($past(sample_data_in) ^ $past(scramble_data_in)))
        else $error("scrambled data wrong");
    AST_ALT: assert property (go && fmt == 6'h04 ##1 fmt == 6'h04
        |-> out_data_out == ($past(sample_data_in) ^ 16'hAAAA))
        else $error("alternate polarity wrong");
    AST_ONES: assert property (go && fmt[5:3] == 3'h3 ##1 fmt[5:3] == 3'h3 |-> po == 17'h1FFFF)
        else $error("all ones pattern wrong");
    AST_CHECK: assert property (go && fmt[5:3] == 3'h5 ##1 go && fmt[5:3] == 3'h5
        ##1 fmt[5:3] == 3'h5 |-> po == ~$past(po))
        else $error("checkerboard did not flip");
    AST_IDLE: assert property (spi_cs_n_in [*5] |-> !spi_sdo_oe_out)
        else $error("read line driven while deselected");
    // Main scenarios reached
    cover property (go && fmt[5:3] == 3'h5 ##1 go);
    cover property ($rose(spi_sdo_oe_out));
    cover property (go && fmt == 6'h04);
endmodule
bind amc_mode_regs amc_mode_regs_monitor mon (.clk_in, .rst_n_in, .clk_en_in, .spi_cs_n_in, .spi_sdo_oe_out,
    .sample_valid_in, .sample_data_in, .scramble_data_in, .out_data_out, .overflow_bit_out, .gain_select_out,
    .test_pattern_sel_out, .alt_polarity_en_out, .scrambler_en_out, .signed_format_sel_out);

// file: amc_mode_regs_tb.sv
// Testbench for the mode control register bank
`timescale 1ns/100ps
// ====
// Bench
module amc_mode_regs_tb;
    reg clk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg clk_en_in = 1'b1;
    reg vld = 1'b0;
    reg ovf_in = 1'b0;
    reg [15:0] din = 16'h0000;
    reg [15:0] scr_in = 16'h0000;
    reg [7:0] rv;
    reg [16:0] o1, o2;
    wire cs_n, sck, sdi, sdo, sdo_oe, ovf, gn, dn, pd, et, ko, inv, stab, trm, hz, cm, alt, scr, sgn;
    wire [15:0] dout;
    wire [1:0] ph;
    wire [2:0] cur, tp;
    wire sdo_line = sdo_oe ? sdo : 1'b1; // Pull-up when released
    wire [21:0] ctl = {gn, dn, pd, et, ko, inv, ph, stab, cur, trm, hz, cm, tp, alt, scr, sgn};
    int miscompares = 0;
    int n_tests = 0;
    // 100 MHz clock
    always #5 clk_in = ~clk_in;
    amc_mode_regs dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .spi_cs_n_in(cs_n),
        .spi_sck_in(sck), .spi_sdi_in(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_out(sdo_oe), .sample_valid_in(vld),
        .sample_data_in(din), .sample_overflow_in(ovf_in), .scramble_data_in(scr_in), .out_data_out(dout),
        .overflow_bit_out(ovf), .gain_select_out(gn), .dither_off_n_out(dn), .power_down_out(pd),
        .encode_term_en_out(et), .keepalive_osc_off_out(ko), .outclk_invert_out(inv),
        .outclk_phase_delay_out(ph), .duty_stabilizer_en_out(stab), .driver_current_sel_out(cur),
        .output_term_en_out(trm), .output_hiz_out(hz), .cmos_mode_out(cm), .test_pattern_sel_out(tp),
        .alt_polarity_en_out(alt), .scrambler_en_out(scr), .signed_format_sel_out(sgn));
    amc_spi_host host (.clk_in(clk_in), .sdo_line_in(sdo_line), .cs_n_out(cs_n), .sck_out(sck), .sdi_out(sdi));
    // Compare and count
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d, 0, rv);
    endtask
    task automatic rd(input logic [6:0] a);
        host.xfer(1'b1, a, 8'h00, 0, rv);
    endtask
    // One sample per call; valid stays up for back-to-back calls
    task automatic smp(input logic [16:0] v, output logic [16:0] o);
        {ovf_in, din} = v;
        vld = 1'b1;
        @(negedge clk_in);
        o = {ovf, dout};
    endtask
    task automatic t_conv;
        for (int b = 1; b < 4; b++) begin
            wr(7'h01, 8'hF1 | (8'h01 << b));
            rd(7'h01);
            check("converter readback", rv, 8'h01 << b);
            check("converter controls", {gn, dn, pd, 1'b0}, 4'h1 << b);
        end
    endtask
    task automatic t_clock;
        logic [7:0] v[7] = '{8'hC1, 8'h03, 8'h05, 8'h07, 8'h09, 8'h11, 8'h21};
        foreach (v[i]) begin
            wr(7'h03, v[i]);
            rd(7'h03);
            check("clock readback", rv, v[i] & 8'h3F);
            check("clock controls", {et, ko, inv, ph, stab}, v[i] & 8'h3F);
        end
    endtask
    task automatic t_outmode;
        for (int c = 0; c < 8; c++) begin
            wr(7'h04, {1'b1, c[2:0], c[0], c[1], 2'b11});
            rd(7'h04);
            check("output readback", rv, {1'b0, c[2:0], c[0], c[1], 2'b01});
            check("output controls", {cur, trm, hz, cm}, {c[2:0], c[0], c[1], 1'b1});
        end
    endtask
    task automatic t_soft;
        for (int a = 1; a < 6; a++) wr(a[6:0], 8'hFF);
        wr(7'h00, 8'h7F);
        rd(7'h01);
        check("reset without bit 7", rv, 8'h0E);
        wr(7'h00, 8'h80);
        for (int a = 0; a < 7; a++) begin
            rd(a[6:0]);
            check("after soft reset", rv, 8'h00);
        end
        check("controls after soft reset", ctl, 22'h000000);
        host.xfer(1'b0, 7'h01, 8'h08, 4, rv);
        rd(7'h01);
        check("aborted frame", rv, 8'h00);
        wr(7'h01, 8'h08);
        rd(7'h01);
        check("write after soft reset", rv, 8'h08);
    endtask
    task automatic t_pattern;
        logic [2:0] code[4] = '{3'h1, 3'h3, 3'h5, 3'h7};
        logic [16:0] e[4] = '{17'h00000, 17'h1FFFF, 17'h15555, 17'h00000};
        for (int i = 0; i < 4; i++) begin
            wr(7'h05, {2'b11, code[i], 3'b111});
            check("pattern controls", {tp, alt, scr, sgn}, {code[i], 3'b111});
            smp(17'h0C3A5, o1);
            smp(17'h1BEEF, o2);
            vld = 1'b0;
            // Phase starts at zero and every code takes an even number of samples
            check("pattern value", o1, e[i]);
            check("pattern step", o1 ^ o2, i > 1 ? 17'h1FFFF : 17'h00000);
        end
    endtask
    task automatic t_format;
        logic [15:0] x;
        scr_in = 16'h0F0F;
        for (int m = 0; m < 8; m++) begin
            wr(7'h05, m[7:0]);
            check("format controls", {tp, alt, scr, sgn}, m[5:0]);
            smp(17'h11234, o1);
            vld = 1'b0;
            x = 16'h1234 ^ {m[0], 15'h0000} ^ (m[1] ? 16'h0F0F : 16'h0000) ^ (m[2] ? 16'hAAAA : 16'h0000);
            check("formatted data", o1, {1'b1, x});
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Main sequence after a 20-cycle reset
    initial begin
        repeat (20) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (3) @(negedge clk_in);
        for (int a = 0; a < 6; a++) begin
            rd(a[6:0]);
            check("reset readback", rv, 8'h00);
        end
        check("reset controls", ctl, 22'h000000);
        t_conv;
        t_clock;
        t_outmode;
        t_soft;
        t_pattern;
        t_format;
        summarize;
    end
    // Hang guard
    initial begin
        repeat (60000) @(negedge clk_in);
        miscompares++;
        summarize;
    end
endmodule
